//--- dtc_pkg.sv
// dtc_pkg: constants, register map, carrier types for the termination control block
// assumes: one register word per aligned 32-bit address, link signals sampled on the link clock
package dtc_pkg;

  // ==========================================================================
  // register bus and map
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam logic [AW-1:0] OFS_MR1 = 8'h00;
  localparam logic [AW-1:0] OFS_MR2 = 8'h04;
  localparam logic [AW-1:0] OFS_MR5 = 8'h08;
  localparam logic [AW-1:0] OFS_LAT = 8'h0c;
  localparam logic [AW-1:0] OFS_MODE = 8'h10;
  localparam logic [AW-1:0] OFS_STAT = 8'h14;

  // ==========================================================================
  // field positions
  localparam int unsigned MR_W = 14;
  localparam int unsigned NOM_LSB = 8;
  localparam int unsigned WRT_LSB = 9;
  localparam int unsigned PARK_LSB = 6;
  localparam int unsigned IBD_BIT = 5;
  localparam int unsigned DYN_BIT_A = 9;
  localparam int unsigned DYN_BIT_B = 10;
  localparam int unsigned CWL_LSB = 0;
  localparam int unsigned AL_LSB = 8;
  localparam int unsigned PL_LSB = 16;
  localparam int unsigned PRE2_BIT = 0;
  localparam int unsigned CRC_BIT = 1;
  localparam int unsigned DLLOFF_BIT = 2;
  localparam int unsigned BURST_LSB = 4;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_WR = 1;
  localparam int unsigned ST_NOM = 2;

  // ==========================================================================
  // reset values and write masks
  localparam logic [MR_W-1:0] MR_RST = 14'h0000;
  localparam logic [DW-1:0] LAT_RST = 32'h0000_0009;
  localparam logic [DW-1:0] LAT_MASK = 32'h0007_1f1f;
  localparam logic [DW-1:0] MODE_RST = 32'h0000_0000;
  localparam logic [DW-1:0] MODE_MASK = 32'h0000_0037;
  localparam logic [1:0] BURST_BL8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_BC4 = 2'h2;

  // ==========================================================================
  // latency arithmetic, in link clocks
  localparam int unsigned LAT_W = 6;
  localparam int unsigned HIST_D = 64;
  localparam logic [6:0] ON_SUB_1T = 7'h02;
  localparam logic [6:0] ON_SUB_2T = 7'h03;
  localparam logic [3:0] BC4_1T_NOCRC = 4'h4;
  localparam logic [3:0] BC4_1T_CRC = 4'h7;
  localparam logic [3:0] BC4_2T_NOCRC = 4'h5;
  localparam logic [3:0] BC4_2T_CRC = 4'h8;
  localparam logic [3:0] BL8_1T_NOCRC = 4'h6;
  localparam logic [3:0] BL8_1T_CRC = 4'h7;
  localparam logic [3:0] BL8_2T_NOCRC = 4'h7;
  localparam logic [3:0] BL8_2T_CRC = 4'h8;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {TERM_OFF, TERM_WR, TERM_NOM, TERM_PARK} dtc_term_t;

  typedef struct packed {
    logic [2:0] nominal_termination;
    logic [2:0] rtt_wr;
    logic [2:0] rtt_park;
    logic dyn_en;
    logic ibd;
    logic [4:0] cwl;
    logic [4:0] al;
    logic [2:0] pl;
    logic pre2;
    logic crc;
    logic dll_off;
    logic [1:0] burst;
  } dtc_cfg_t;

  localparam dtc_cfg_t CFG_RST = '{nominal_termination: 3'h0, rtt_wr: 3'h0, rtt_park: 3'h0, dyn_en: 1'b0,
                                   ibd: 1'b0, cwl: 5'h09, al: 5'h00, pl: 3'h0, pre2: 1'b0,
                                   crc: 1'b0, dll_off: 1'b0, burst: 2'h0};

  typedef struct packed {
    logic odt;
    logic cke;
    logic wr;
    logic bc4;
  } dtc_pins_t;

endpackage : dtc_pkg

//--- dtc_termination_control.sv
// dtc_termination_control: data termination selection with register port
// assumes: link pins are synchronous to i_link_ck; registers written on i_core_clk
`timescale 1ns/1ns
module dtc_termination_control
  import dtc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DW-1:0] o_rdata,
  input wire logic i_link_ck,
  input wire dtc_pins_t i_pins,
  output dtc_term_t o_term_sel,
  output logic [2:0] o_term_code
);

  // ==========================================================================
  // functions
  function automatic logic [3:0] off_add(input logic bc4, input logic pre2, input logic crc);
    logic [3:0] r;
    r = 4'h0;
    case ({bc4, pre2, crc})
      3'b100: r = BC4_1T_NOCRC;
      3'b101: r = BC4_1T_CRC;
      3'b110: r = BC4_2T_NOCRC;
      3'b111: r = BC4_2T_CRC;
      3'b000: r = BL8_1T_NOCRC;
      3'b001: r = BL8_1T_CRC;
      3'b010: r = BL8_2T_NOCRC;
      default: r = BL8_2T_CRC;
    endcase
    return r;
  endfunction : off_add

  function automatic logic [LAT_W-1:0] clamp_lat(input logic [6:0] wl, input logic [6:0] sub);
    logic [6:0] d;
    d = 7'h00;
    if (wl <= sub)
    begin
      d = 7'h01;
    end
    else
    begin
      d = wl - sub;
    end
    if (d > 7'(HIST_D - 1))
    begin
      d = 7'(HIST_D - 1);
    end
    return d[LAT_W-1:0];
  endfunction : clamp_lat

  // ==========================================================================
  // core domain registers
  logic [MR_W-1:0] mr1_q;
  logic [MR_W-1:0] mr2_q;
  logic [MR_W-1:0] mr5_q;
  logic [DW-1:0] lat_q;
  logic [DW-1:0] mode_q;
  logic [DW-1:0] rdata_q;
  dtc_cfg_t cfg_c;
  dtc_cfg_t send_q;
  logic req_q;
  logic pend_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic wr_s1_q;
  logic wr_s2_q;
  logic nom_s1_q;
  logic nom_s2_q;
  logic cfg_wr;
  logic busy;
  // link-domain flops read by the core-side synchronisers
  logic ack_l_q;
  logic sts_wr_q;
  logic sts_nom_q;

  assign cfg_wr = i_wr && (i_addr == OFS_MR1 || i_addr == OFS_MR2 || i_addr == OFS_MR5 ||
                           i_addr == OFS_LAT || i_addr == OFS_MODE);
  assign busy = pend_q || (req_q != ack_s2_q);

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      mr1_q <= MR_RST;
      mr2_q <= MR_RST;
      mr5_q <= MR_RST;
      lat_q <= LAT_RST;
      mode_q <= MODE_RST;
    end
    else if (i_wr)
    begin
      case (i_addr)
        OFS_MR1: mr1_q <= i_wdata[MR_W-1:0];
        OFS_MR2: mr2_q <= i_wdata[MR_W-1:0];
        OFS_MR5: mr5_q <= i_wdata[MR_W-1:0];
        OFS_LAT: lat_q <= i_wdata & LAT_MASK;
        OFS_MODE: mode_q <= i_wdata & MODE_MASK;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    cfg_c = CFG_RST;
    cfg_c.nominal_termination = mr1_q[NOM_LSB +: 3];
    cfg_c.rtt_wr = mr2_q[WRT_LSB +: 3];
    cfg_c.rtt_park = mr5_q[PARK_LSB +: 3];
    cfg_c.dyn_en = mr2_q[DYN_BIT_A] | mr2_q[DYN_BIT_B];
    cfg_c.ibd = mr5_q[IBD_BIT];
    cfg_c.cwl = lat_q[CWL_LSB +: 5];
    cfg_c.al = lat_q[AL_LSB +: 5];
    cfg_c.pl = lat_q[PL_LSB +: 3];
    cfg_c.pre2 = mode_q[PRE2_BIT];
    cfg_c.crc = mode_q[CRC_BIT];
    cfg_c.dll_off = mode_q[DLLOFF_BIT];
    cfg_c.burst = mode_q[BURST_LSB +: 2];
  end

  // ==========================================================================
  // configuration handshake toward the link side
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      send_q <= CFG_RST;
      req_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else if (!pend_q || req_q != ack_s2_q)
    begin
      pend_q <= pend_q | cfg_wr;
    end
    else
    begin
      send_q <= cfg_c;
      req_q <= ~req_q;
      pend_q <= cfg_wr;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      nom_s1_q <= 1'b0;
      nom_s2_q <= 1'b0;
    end
    else
    begin
      ack_s1_q <= ack_l_q;
      ack_s2_q <= ack_s1_q;
      wr_s1_q <= sts_wr_q;
      wr_s2_q <= wr_s1_q;
      nom_s1_q <= sts_nom_q;
      nom_s2_q <= nom_s1_q;
    end
  end

  // ==========================================================================
  // read port: data only in the cycle after the strobe
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !i_rd)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      case (i_addr)
        OFS_MR1: rdata_q <= {18'h00000, mr1_q};
        OFS_MR2: rdata_q <= {18'h00000, mr2_q};
        OFS_MR5: rdata_q <= {18'h00000, mr5_q};
        OFS_LAT: rdata_q <= lat_q;
        OFS_MODE: rdata_q <= mode_q;
        OFS_STAT: rdata_q <= {29'h0000_0000, nom_s2_q, wr_s2_q, busy};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign o_rdata = rdata_q;

  // ==========================================================================
  // link domain: reset, configuration capture
  logic lrst_s1_q;
  logic lrst_q;
  logic req_s1_q;
  logic req_s2_q;
  dtc_cfg_t cfg_l_q;

  always_ff @(posedge i_link_ck)
  begin
    lrst_s1_q <= i_rst;
    lrst_q <= lrst_s1_q;
  end

  always_ff @(posedge i_link_ck)
  begin
    if (lrst_q)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_l_q <= 1'b0;
      cfg_l_q <= CFG_RST;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      ack_l_q <= req_s2_q;
      if (req_s2_q != ack_l_q)
      begin
        cfg_l_q <= send_q;
      end
    end
  end

  // ==========================================================================
  // link domain: latencies
  logic [6:0] wl_q;
  logic [LAT_W-1:0] on_lat_q;

  always_ff @(posedge i_link_ck)
  begin
    if (lrst_q)
    begin
      wl_q <= 7'h00;
      on_lat_q <= 6'h01;
    end
    else
    begin
      wl_q <= {2'b00, cfg_l_q.cwl} + {2'b00, cfg_l_q.al} + {4'h0, cfg_l_q.pl};
      on_lat_q <= clamp_lat(wl_q, cfg_l_q.pre2 ? ON_SUB_2T : ON_SUB_1T);
    end
  end

  // ==========================================================================
  // link domain: pin history and requests
  dtc_pins_t pins_q;
  logic [HIST_D-1:0] odt_hist_q;
  logic [HIST_D-1:0] wr_hist_q;
  logic [HIST_D-1:0] bc4_hist_q;
  logic [3:0] wr_left_q;
  logic pd_ibd;
  logic wr_take;
  logic cmd_bc4;
  logic on_hit;
  logic nom_req;
  logic wr_act;

  assign pd_ibd = cfg_l_q.ibd && !pins_q.cke;
  assign wr_take = pins_q.wr && cfg_l_q.dyn_en && !cfg_l_q.dll_off;
  assign cmd_bc4 = (cfg_l_q.burst == BURST_BC4) || (cfg_l_q.burst == BURST_OTF && pins_q.bc4);
  assign on_hit = wr_hist_q[on_lat_q] && !cfg_l_q.dll_off;
  assign wr_act = wr_left_q != 4'h0;

  always_comb
  begin
    if (pd_ibd)
    begin
      nom_req = 1'b0;
    end
    else if (cfg_l_q.dll_off)
    begin
      nom_req = pins_q.odt;
    end
    else
    begin
      nom_req = odt_hist_q[on_lat_q];
    end
  end

  always_ff @(posedge i_link_ck)
  begin
    if (lrst_q)
    begin
      pins_q <= '0;
      odt_hist_q <= '0;
      wr_hist_q <= '0;
      bc4_hist_q <= '0;
    end
    else
    begin
      pins_q <= i_pins;
      odt_hist_q <= {odt_hist_q[HIST_D-2:0], pins_q.odt && !pd_ibd};
      wr_hist_q <= {wr_hist_q[HIST_D-2:0], wr_take};
      bc4_hist_q <= {bc4_hist_q[HIST_D-2:0], cmd_bc4};
    end
  end

  always_ff @(posedge i_link_ck)
  begin
    if (lrst_q || cfg_l_q.dll_off)
    begin
      wr_left_q <= 4'h0;
    end
    else if (on_hit)
    begin
      wr_left_q <= off_add(bc4_hist_q[on_lat_q], cfg_l_q.pre2, cfg_l_q.crc);
    end
    else if (wr_act)
    begin
      wr_left_q <= wr_left_q - 4'h1;
    end
  end

  // ==========================================================================
  // link domain: termination selection
  dtc_term_t sel_q;
  logic [2:0] code_q;

  always_ff @(posedge i_link_ck)
  begin
    if (lrst_q)
    begin
      sel_q <= TERM_OFF;
      code_q <= 3'h0;
      sts_wr_q <= 1'b0;
      sts_nom_q <= 1'b0;
    end
    else
    begin
      sts_wr_q <= wr_act;
      sts_nom_q <= nom_req;
      if (wr_act && cfg_l_q.rtt_wr != 3'h0)
      begin
        sel_q <= TERM_WR;
        code_q <= cfg_l_q.rtt_wr;
      end
      else if (nom_req && cfg_l_q.nominal_termination != 3'h0)
      begin
        sel_q <= TERM_NOM;
        code_q <= cfg_l_q.nominal_termination;
      end
      else if (cfg_l_q.rtt_park != 3'h0)
      begin
        sel_q <= TERM_PARK;
        code_q <= cfg_l_q.rtt_park;
      end
      else
      begin
        sel_q <= TERM_OFF;
        code_q <= 3'h0;
      end
    end
  end

  assign o_term_sel = sel_q;
  assign o_term_code = code_q;

  // ==========================================================================
  // checks
  dll_no_wr_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    cfg_l_q.dll_off && $past(cfg_l_q.dll_off, 2) |-> o_term_sel != TERM_WR)
    else $error("write termination while dll off");

  wr_first_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    wr_act && cfg_l_q.rtt_wr != 3'h0 |=> o_term_sel == TERM_WR && o_term_code == $past(cfg_l_q.rtt_wr))
    else $error("write termination lost priority");

  off_load_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    on_hit && bc4_hist_q[on_lat_q] && !cfg_l_q.pre2 && !cfg_l_q.crc |=> wr_left_q == 4'h4 ##1 wr_left_q <= 4'h4)
    else $error("bc4 off latency wrong");

  bl8_len_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    on_hit && !bc4_hist_q[on_lat_q] && !cfg_l_q.pre2 && !cfg_l_q.crc && !cfg_l_q.dll_off
    |=> wr_left_q == 4'h6)
    else $error("bl8 off latency wrong");

  on_lat_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    $stable(wl_q) && $stable(cfg_l_q.pre2) && wl_q > 7'h08 && wl_q < 7'h40 |=>
    on_lat_q == 6'($past(wl_q) - ($past(cfg_l_q.pre2) ? 7'h03 : 7'h02)))
    else $error("on latency mismatch");

  pd_no_nom_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    pd_ibd |=> o_term_sel != TERM_NOM)
    else $error("nominal during power down");

  async_pin_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    cfg_l_q.dll_off && !wr_act && !pd_ibd && pins_q.odt && cfg_l_q.nominal_termination != 3'h0 |=> o_term_sel == TERM_NOM)
    else $error("async nominal not taken");

  park_low_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    !wr_act && !nom_req && cfg_l_q.rtt_park != 3'h0 |=>
    o_term_sel == TERM_PARK && o_term_code == $past(cfg_l_q.rtt_park))
    else $error("park not selected");

  dyn_off_a: assert property (@(posedge i_link_ck) disable iff (lrst_q)
    !cfg_l_q.dyn_en && pins_q.wr |=> !wr_hist_q[0])
    else $error("write taken with dynamic switching off");

  rd_once_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : dtc_termination_control

//--- dtc_ctrl_model.sv
// dtc_ctrl_model: behavioural memory controller driving the termination pins
// assumes: the bench issues commands through its tasks, never on two adjacent clocks
`timescale 1ns/1ns
module dtc_ctrl_model
  import dtc_pkg::*;
#(
  parameter int CPDED = 4,
  parameter int XP = 6
)
(
  input wire logic i_link_ck,
  output dtc_pins_t o_pins
);
  // ==========================================================================
  // pin drive
  initial o_pins = '{odt: 1'b0, cke: 1'b1, wr: 1'b0, bc4: 1'b0};
  // command lasts one clock; the burst line then stops holding its value
  always @(posedge i_link_ck)
  begin
    if (o_pins.wr)
    begin
      o_pins.wr <= 1'b0;
      o_pins.bc4 <= ~o_pins.bc4;
    end
  end
  task automatic set_odt(input logic v);
    @(posedge i_link_ck);
    o_pins.odt <= v;
  endtask : set_odt
  task automatic send_wr(input logic b);
    @(posedge i_link_ck);
    o_pins.wr <= 1'b1;
    o_pins.bc4 <= b;
  endtask : send_wr
  // odt held steady until the buffer-disable delay, then left floating
  task automatic pd_enter(input int n_float);
    @(posedge i_link_ck);
    o_pins.cke <= 1'b0;
    repeat (CPDED) @(posedge i_link_ck);
    repeat (n_float)
    begin
      @(posedge i_link_ck);
      o_pins.odt <= ~o_pins.odt;
    end
  endtask : pd_enter
  task automatic pd_exit();
    @(posedge i_link_ck);
    o_pins.cke <= 1'b1;
    o_pins.odt <= 1'b0;
    repeat (XP) @(posedge i_link_ck);
  endtask : pd_exit
endmodule : dtc_ctrl_model

//--- tb_dtc_termination_control.sv
// tb_dtc_termination_control: self-checking bench for the termination control block
// assumes: controller model on the link side, register port driven from the bench
`timescale 1ns/1ns
module tb_dtc_termination_control
  import dtc_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_link_ck = 1'b0;
  logic i_rst = 1'b1;
  logic [AW-1:0] i_addr = '0;
  logic [DW-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DW-1:0] o_rdata;
  dtc_pins_t pins;
  dtc_term_t o_term_sel;
  logic [2:0] o_term_code;
  int error_cnt = 0;
  int comparisons = 0;
  dtc_cfg_t c;
  logic [DW-1:0] rd;
  logic od;
  int n;
  int m;
  // write window length indexed by {bc4, 2-clk preamble, crc}
  localparam int OFFN[8] = '{6, 7, 7, 8, 4, 7, 5, 8};
  localparam logic [AW-1:0] RA[5] = '{OFS_MR1, OFS_MR2, OFS_MR5, OFS_LAT, OFS_MODE};
  localparam logic [DW-1:0] RV[5] = '{32'h0, 32'h0, 32'h0, LAT_RST, MODE_RST};

  always #4 i_core_clk = ~i_core_clk;
  always #24 i_link_ck = ~i_link_ck;

  dtc_ctrl_model #(.CPDED(4), .XP(6)) ctl (.i_link_ck(i_link_ck), .o_pins(pins));
  dtc_termination_control uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link_ck(i_link_ck),
    .i_pins(pins), .o_term_sel(o_term_sel), .o_term_code(o_term_code));

  // ==========================================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd_reg
  task automatic apply(input dtc_cfg_t k);
    wr_reg(OFS_MR1, 32'(k.nominal_termination) << NOM_LSB);
    wr_reg(OFS_MR2, 32'(k.rtt_wr) << WRT_LSB);
    wr_reg(OFS_MR5, (32'(k.rtt_park) << PARK_LSB) | (32'(k.ibd) << IBD_BIT));
    wr_reg(OFS_LAT, {13'h0, k.pl, 3'h0, k.al, 3'h0, k.cwl});
    wr_reg(OFS_MODE, {26'h0, k.burst, 1'b0, k.dll_off, k.crc, k.pre2});
    n = 0;
    do
    begin
      rd_reg(OFS_STAT, rd);
      n++;
    end
    while (rd[ST_BUSY] !== 1'b0 && n < 100);
    chk("cfg_busy", rd[ST_BUSY], 1'b0);
    repeat (6) @(posedge i_link_ck);
  endtask : apply
  task automatic rnd_cfg();
    c = CFG_RST;
    c.nominal_termination = 3'($urandom_range(7, 1));
    c.rtt_wr = 3'($urandom_range(3, 1));
    c.rtt_park = 3'($urandom_range(7, 1));
    c.cwl = 5'($urandom_range(20, 9));
    c.al = 5'($urandom_range(6, 0));
    c.pl = 3'($urandom_range(4, 0));
    c.pre2 = 1'($urandom_range(1, 0));
  endtask : rnd_cfg
  function automatic int onl(dtc_cfg_t k);
    int v;
    v = int'(k.cwl) + int'(k.al) + int'(k.pl) - (k.pre2 ? 3 : 2);
    return (v < 1) ? 1 : v;
  endfunction : onl
  task automatic lat(input dtc_term_t t, output int k);
    k = 0;
    do
    begin
      @(posedge i_link_ck);
      #1;
      k++;
    end
    while (o_term_sel !== t && k < 100);
  endtask : lat
  // counts link clocks showing the given level over a span
  task automatic count_sel(input dtc_term_t t, input int span, output int k);
    k = 0;
    repeat (span)
    begin
      @(posedge i_link_ck);
      #1;
      if (o_term_sel === t)
        k++;
    end
  endtask : count_sel

  // ==========================================================================
  // tests
  initial
  begin
    n = $urandom(32'h680b);
    repeat (30) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_link_ck);
    chk("sel_rst", o_term_sel, TERM_OFF);
    for (int i = 0; i < 5; i++)
    begin
      rd_reg(RA[i], rd);
      chk("reg_rst", rd, RV[i]);
    end
    wr_reg(OFS_LAT, '1);
    rd_reg(OFS_LAT, rd);
    chk("lat_mask", rd, LAT_MASK);
    wr_reg(8'h18, $urandom());
    rd_reg(8'h18, rd);
    chk("unmapped", rd, 32'h0);
    @(posedge i_core_clk);
    #1;
    chk("rdata_idle", o_rdata, 32'h0);
    $display("test done: registers");
    repeat (3)
    begin
      rnd_cfg();
      apply(c);
      ctl.set_odt(1'b1);
      lat(TERM_NOM, n);
      chk("nom_on_lat", n, onl(c) + 3);
      chk("nom_code", o_term_code, c.nominal_termination);
      ctl.set_odt(1'b0);
      lat(TERM_PARK, n);
      chk("nom_off_lat", n, onl(c) + 3);
      chk("park_code", o_term_code, c.rtt_park);
    end
    c.nominal_termination = 3'h0;
    apply(c);
    ctl.set_odt(1'b1);
    count_sel(TERM_PARK, onl(c) + 6, n);
    chk("nom_dis_cnt", n, onl(c) + 6);
    chk("nom_dis", o_term_sel, TERM_PARK);
    c.rtt_park = 3'h0;
    apply(c);
    chk("all_dis", o_term_sel, TERM_OFF);
    ctl.set_odt(1'b0);
    $display("test done: nominal");
    for (int i = 0; i < 8; i++)
    begin
      rnd_cfg();
      c.pre2 = i[0];
      c.crc = i[1];
      m = $urandom_range(1, 0);
      c.burst = m ? BURST_OTF : (i[2] ? BURST_BC4 : BURST_BL8);
      apply(c);
      od = 1'($urandom_range(1, 0));
      ctl.set_odt(od);
      repeat (onl(c) + 4) @(posedge i_link_ck);
      ctl.send_wr(m ? i[2] : ~i[2]);
      lat(TERM_WR, n);
      chk("wr_on_lat", n, onl(c) + 4);
      chk("wr_code", o_term_code, c.rtt_wr);
      n = 0;
      while (o_term_sel === TERM_WR && n < 30)
      begin
        @(posedge i_link_ck);
        #1;
        n++;
      end
      chk("wr_len", n, OFFN[{i[2], i[0], i[1]}]);
      chk("wr_back", o_term_sel, od ? TERM_NOM : TERM_PARK);
    end
    ctl.set_odt(1'b0);
    $display("test done: write");
    for (int j = 0; j < 3; j++)
    begin
      rnd_cfg();
      c.rtt_wr = (j == 0) ? 3'h0 : ((j == 1) ? 3'h4 : 3'h1);
      c.dll_off = (j == 2);
      apply(c);
      ctl.send_wr(1'($urandom_range(1, 0)));
      count_sel(TERM_WR, 40, m);
      chk("wr_blocked", m, 0);
    end
    for (int j = 0; j < 2; j++)
    begin
      c.al = j ? 5'h0a : 5'h00;
      c.pl = j ? 3'h4 : 3'h0;
      apply(c);
      ctl.set_odt(1'b1);
      lat(TERM_NOM, n);
      ctl.set_odt(1'b0);
      lat(TERM_PARK, m);
      chk("async_on", n, 2);
      chk("async_off", m, 2);
    end
    $display("test done: disable");
    rnd_cfg();
    c.ibd = 1'b1;
    apply(c);
    ctl.set_odt(1'b1);
    lat(TERM_NOM, n);
    ctl.pd_enter($urandom_range(8, 2));
    count_sel(TERM_NOM, 20, m);
    chk("pd_ibd", m, 0);
    ctl.pd_exit();
    ctl.set_odt(1'b1);
    lat(TERM_NOM, n);
    chk("pd_exit", n, onl(c) + 3);
    ctl.pd_enter(0);
    ctl.pd_exit();
    c.ibd = 1'b0;
    apply(c);
    ctl.set_odt(1'b1);
    lat(TERM_NOM, n);
    ctl.pd_enter(0);
    count_sel(TERM_NOM, 20, m);
    chk("pd_no_ibd", m, 20);
    ctl.pd_exit();
    $display("test done: power-down");
    report_and_stop();
  end

  initial
  begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : tb_dtc_termination_control
